/* hw/bwd_top.sv */
// bus stall timer and deadman watchdog with a wishbone register file
// assumes i_bus_frame is asynchronous to I_CLK; all else on I_CLK
// Summary of operation
// - stall timer runs only when enable set
// - stall count ticks while bus frame asserted
// - limit reached raises nmi if enabled
// - stall limit is field times clock period
// - stall limit resets to 8000_0000
// - watchdog runs only when enable set
// - watchdog period is field times clock
// - writing kick one restarts watchdog count
// - kick bit write-only, self clearing
// - period expiry without kick resets cpu
// - elapsed register shows count, zero after reset
// - watchdog period resets to 8000_0000
// - stall control resets to zero
`timescale 1ns/1ps
`default_nettype none
module bwd_top
   import bwd_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_RSTN,
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire logic I_WB_WE,
   input wire logic [3:0] I_WB_SEL,
   input wire logic [bwd_pkg::BWD_AW-1:0] I_WB_ADR,
   input wire logic [31:0] I_WB_DAT,
   output logic [31:0] O_WB_DAT,
   output logic O_WB_ACK,
   input wire logic I_BUS_FRAME,
   output logic O_NMI,
   output logic O_CPU_RST,
   output logic O_IRQ
);
   import bwd_pkg::*;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // bus slave
   // ---------------------------------------------------------------
   bwd_wb_req_s req;
   logic ack_reg;
   logic [31:0] rdat_reg;
   logic wr_go;
   logic rd_go;
   logic [31:0] stall_ctrl_reg;
   logic [31:0] stall_limit_reg;
   logic [31:0] dead_ctrl_reg;
   logic [31:0] dead_period_reg;
   logic [31:0] dead_count_reg;
   logic [BWD_NEV-1:0] nmi_en_reg;
   logic [BWD_NEV-1:0] status_reg;
   logic kick;

   assign req = '{cyc: I_WB_CYC, stb: I_WB_STB, we: I_WB_WE, sel: I_WB_SEL, adr: I_WB_ADR, dat: I_WB_DAT};
   assign wr_go = req.cyc & req.stb & req.we & ~ack_reg;
   assign rd_go = req.cyc & req.stb & ~req.we & ~ack_reg;
   // write-only kick: acts for the cycle of the write, never stored
   assign kick = wr_go && req.adr == BWD_OFF_DEAD_CLEAR && req.sel[0] && req.dat[BWD_KICK_BIT];

   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req.cyc & req.stb & ~ack_reg;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         rdat_reg <= BWD_RST_ZERO;
      end else if (rd_go) begin
         case (req.adr)
            BWD_OFF_STALL_CTRL: rdat_reg <= stall_ctrl_reg;
            BWD_OFF_STALL_LIMIT: rdat_reg <= stall_limit_reg;
            BWD_OFF_DEAD_CTRL: rdat_reg <= dead_ctrl_reg;
            BWD_OFF_DEAD_PERIOD: rdat_reg <= dead_period_reg;
            BWD_OFF_DEAD_ELAPSED: rdat_reg <= dead_count_reg;
            BWD_OFF_NMI_ENABLE: rdat_reg <= {30'h0, nmi_en_reg};
            BWD_OFF_IRQ_STATUS: rdat_reg <= {30'h0, status_reg};
            default: rdat_reg <= BWD_UNMAPPED;
         endcase
      end
   end

   assign O_WB_ACK = ack_reg;
   assign O_WB_DAT = rdat_reg;

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         stall_ctrl_reg <= BWD_RST_ZERO;
         stall_limit_reg <= BWD_RST_LIMIT;
         dead_ctrl_reg <= BWD_RST_ZERO;
         dead_period_reg <= BWD_RST_PERIOD;
         nmi_en_reg <= '0;
      end else if (wr_go) begin
         case (req.adr)
            BWD_OFF_STALL_CTRL: stall_ctrl_reg <= merge_bytes(stall_ctrl_reg, req.dat, req.sel) & BWD_ONE;
            BWD_OFF_STALL_LIMIT: stall_limit_reg <= merge_bytes(stall_limit_reg, req.dat, req.sel);
            BWD_OFF_DEAD_CTRL: dead_ctrl_reg <= merge_bytes(dead_ctrl_reg, req.dat, req.sel) & BWD_ONE;
            BWD_OFF_DEAD_PERIOD: dead_period_reg <= merge_bytes(dead_period_reg, req.dat, req.sel);
            BWD_OFF_NMI_ENABLE: begin
               if (req.sel[0]) begin
                  nmi_en_reg <= req.dat[BWD_NEV-1:0];
               end
            end
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // bus stall timer
   // ---------------------------------------------------------------
   logic frame_s1_reg;
   logic frame_s2_reg;
   logic [31:0] stall_count_reg;
   logic stall_hit;

   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         frame_s1_reg <= 1'b0;
         frame_s2_reg <= 1'b0;
      end else begin
         frame_s1_reg <= I_BUS_FRAME;
         frame_s2_reg <= frame_s1_reg;
      end
   end

   // hit once as count steps from one below limit to limit; count holds there so the event fires once per frame
   assign stall_hit = stall_ctrl_reg[BWD_EN_BIT] && frame_s2_reg && stall_count_reg != stall_limit_reg
                      && (stall_count_reg + BWD_ONE) == stall_limit_reg;

   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         stall_count_reg <= BWD_RST_ZERO;
      end else if (!stall_ctrl_reg[BWD_EN_BIT] || !frame_s2_reg) begin
         stall_count_reg <= BWD_RST_ZERO;
      end else if (stall_count_reg != stall_limit_reg) begin
         stall_count_reg <= stall_count_reg + BWD_ONE;
      end
   end

   // ---------------------------------------------------------------
   // deadman watchdog
   // ---------------------------------------------------------------
   bwd_dead_e dead_state_reg;
   logic dead_hit;
   logic [3:0] rst_cnt_reg;

   assign dead_hit = dead_state_reg == BWD_DEAD_RUN && dead_ctrl_reg[BWD_EN_BIT] && !kick
                     && (dead_count_reg + BWD_ONE) >= dead_period_reg;

   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         dead_state_reg <= BWD_DEAD_IDLE;
         dead_count_reg <= BWD_RST_ZERO;
      end else begin
         case (dead_state_reg)
            BWD_DEAD_IDLE: begin
               dead_count_reg <= BWD_RST_ZERO;
               if (dead_ctrl_reg[BWD_EN_BIT]) begin
                  dead_state_reg <= BWD_DEAD_RUN;
               end
            end
            BWD_DEAD_RUN: begin
               if (!dead_ctrl_reg[BWD_EN_BIT]) begin
                  dead_state_reg <= BWD_DEAD_IDLE;
                  dead_count_reg <= BWD_RST_ZERO;
               end else if (kick || dead_hit) begin
                  dead_count_reg <= BWD_RST_ZERO;
               end else begin
                  dead_count_reg <= dead_count_reg + BWD_ONE;
               end
            end
            default: begin
               dead_state_reg <= BWD_DEAD_IDLE;
               dead_count_reg <= BWD_RST_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         rst_cnt_reg <= 4'h0;
         O_CPU_RST <= 1'b0;
      end else if (dead_hit) begin
         rst_cnt_reg <= BWD_CPU_RST_CYC;
         O_CPU_RST <= 1'b1;
      end else if (rst_cnt_reg > 4'h1) begin
         rst_cnt_reg <= rst_cnt_reg - 4'h1;
      end else begin
         rst_cnt_reg <= 4'h0;
         O_CPU_RST <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // events and interrupts
   // ---------------------------------------------------------------
   logic [BWD_NEV-1:0] ev;
   logic [BWD_NEV-1:0] clr;
   assign ev = {dead_hit, stall_hit};
   assign clr = (wr_go && req.adr == BWD_OFF_IRQ_STATUS && req.sel[0]) ? req.dat[BWD_NEV-1:0] : '0;

   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         status_reg <= '0;
      end else begin
         status_reg <= (status_reg & ~clr) | ev;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         O_NMI <= 1'b0;
         O_IRQ <= 1'b0;
      end else begin
         O_NMI <= status_reg[BWD_EV_STALL] & nmi_en_reg[BWD_EV_STALL];
         O_IRQ <= |(status_reg & nmi_en_reg);
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RSTN);

   chk_stall_off_zero: assert property (!stall_ctrl_reg[BWD_EN_BIT] |=> stall_count_reg == 0)
      else $error("stall count moved while disabled");
   chk_stall_counts: assert property (stall_ctrl_reg[0] && frame_s2_reg && stall_count_reg != stall_limit_reg
      && $stable(stall_ctrl_reg) |=> stall_count_reg == $past(stall_count_reg) + 1)
      else $error("stall count did not tick");
   chk_stall_frame_drop: assert property (!frame_s2_reg |=> stall_count_reg == 0)
      else $error("stall count not cleared on frame drop");
   chk_nmi_raise: assert property (stall_hit && nmi_en_reg[0] && !clr[0] |=> ##1 O_NMI)
      else $error("nmi not raised at limit");
   chk_nmi_masked: assert property (!nmi_en_reg[0] && $stable(nmi_en_reg) |=> !O_NMI)
      else $error("nmi while masked");
   chk_dead_idle_zero: assert property (!dead_ctrl_reg[0] ##1 !dead_ctrl_reg[0] |=> dead_count_reg == 0)
      else $error("watchdog count not zero while disabled");
   chk_kick_restart: assert property (kick && dead_state_reg == BWD_DEAD_RUN && dead_ctrl_reg[0]
      |=> dead_count_reg == 0)
      else $error("kick did not restart count");
   // pulse length is checked through its own down counter, one edge at a time
   chk_cpu_rst_start: assert property (dead_hit |=> O_CPU_RST && rst_cnt_reg == BWD_CPU_RST_CYC)
      else $error("cpu reset pulse did not start");
   chk_cpu_rst_hold: assert property (O_CPU_RST && rst_cnt_reg > 4'h1 |=> O_CPU_RST)
      else $error("cpu reset pulse too short");
   chk_cpu_rst_end: assert property (O_CPU_RST && rst_cnt_reg == 4'h1 && !dead_hit |=> !O_CPU_RST)
      else $error("cpu reset pulse too long");
   chk_cpu_rst_cause: assert property ($rose(O_CPU_RST) |-> $past(dead_hit))
      else $error("cpu reset without expiry");
   chk_ack_once: assert property (O_WB_ACK |=> !O_WB_ACK)
      else $error("ack held two cycles");

   // ---------------------------------------------------------------
   // checks: register bus
   // ---------------------------------------------------------------
   // every request is answered exactly one cycle after it is taken
   chk_ack_follows: assert property (req.cyc && req.stb && !O_WB_ACK |=> O_WB_ACK)
      else $error("request not answered in one cycle");
   chk_ack_needs_req: assert property (!(req.cyc && req.stb) |=> !O_WB_ACK)
      else $error("ack without request");
   chk_clear_reads_zero: assert property (rd_go && req.adr == BWD_OFF_DEAD_CLEAR |=> O_WB_DAT == 0)
      else $error("clear register read back nonzero");
   chk_unaligned_read: assert property (rd_go && req.adr[1:0] != 2'h0 |=> O_WB_DAT == 0)
      else $error("unaligned read returned data");
   chk_elapsed_read: assert property (rd_go && req.adr == BWD_OFF_DEAD_ELAPSED
      |=> O_WB_DAT == $past(dead_count_reg))
      else $error("elapsed read does not match count");
   chk_status_read: assert property (rd_go && req.adr == BWD_OFF_IRQ_STATUS
      |=> O_WB_DAT == {30'h0, $past(status_reg)})
      else $error("status read does not match flags");
   chk_ctrl_reserved: assert property (stall_ctrl_reg[31:1] == 31'h0 && dead_ctrl_reg[31:1] == 31'h0)
      else $error("reserved control bits set");
   chk_limit_write: assert property (wr_go && req.adr == BWD_OFF_STALL_LIMIT && req.sel == 4'hF
      |=> stall_limit_reg == $past(req.dat))
      else $error("stall limit write lost");
   chk_period_write: assert property (wr_go && req.adr == BWD_OFF_DEAD_PERIOD && req.sel == 4'hF
      |=> dead_period_reg == $past(req.dat))
      else $error("watchdog period write lost");
   chk_kick_needs_one: assert property (wr_go && req.adr == BWD_OFF_DEAD_CLEAR && !req.dat[0] |-> !kick)
      else $error("kick from a zero write");

   // ---------------------------------------------------------------
   // checks: stall timer
   // ---------------------------------------------------------------
   // the count parks at the limit so a long stall raises one event only
   chk_stall_hold_limit: assert property (stall_ctrl_reg[0] && frame_s2_reg
      && stall_count_reg == stall_limit_reg |=> stall_count_reg == $past(stall_count_reg))
      else $error("stall count ran past limit");
   chk_stall_first_tick: assert property ($rose(frame_s2_reg) && stall_ctrl_reg[0]
      && stall_limit_reg != 0 |=> stall_count_reg == 1)
      else $error("stall count did not start at frame");
   chk_stall_event: assert property (stall_hit |=> status_reg[BWD_EV_STALL])
      else $error("stall event not latched");
   chk_stall_off_quiet: assert property (!stall_ctrl_reg[BWD_EN_BIT] |-> !stall_hit)
      else $error("stall event while disabled");
   chk_stall_frame_quiet: assert property (!frame_s2_reg |-> !stall_hit)
      else $error("stall event without bus frame");
   chk_stall_zero_limit: assert property (stall_limit_reg == 0 |-> !stall_hit)
      else $error("stall event with zero limit");
   chk_frame_sync: assert property (1'b1 |=> frame_s2_reg == $past(frame_s1_reg))
      else $error("frame synchroniser skipped a stage");
   chk_nmi_follows: assert property (1'b1 |=> O_NMI == $past(status_reg[0] & nmi_en_reg[0]))
      else $error("nmi does not follow enabled status");
   chk_nmi_source: assert property ($rose(O_NMI) |-> $past(status_reg[BWD_EV_STALL]))
      else $error("nmi without stall event");

   // ---------------------------------------------------------------
   // checks: deadman watchdog
   // ---------------------------------------------------------------
   // a kick in the expiry cycle saves the cpu; the count never skips
   chk_dead_counts: assert property (dead_state_reg == BWD_DEAD_RUN && dead_ctrl_reg[0]
      && !kick && !dead_hit |=> dead_count_reg == $past(dead_count_reg) + 1)
      else $error("watchdog count did not tick");
   chk_dead_expiry: assert property (dead_hit |=> dead_count_reg == 0 && status_reg[BWD_EV_DEAD])
      else $error("expiry did not restart count or latch event");
   chk_dead_idle_quiet: assert property (dead_state_reg == BWD_DEAD_IDLE |-> !dead_hit)
      else $error("expiry while watchdog idle");
   chk_dead_off_idle: assert property (!dead_ctrl_reg[0] |=> dead_state_reg == BWD_DEAD_IDLE)
      else $error("watchdog kept running when disabled");
   chk_dead_start_zero: assert property (dead_state_reg == BWD_DEAD_IDLE && dead_ctrl_reg[0]
      |=> dead_state_reg == BWD_DEAD_RUN && dead_count_reg == 0)
      else $error("watchdog did not start from zero");
   chk_dead_onehot: assert property ($onehot(dead_state_reg))
      else $error("watchdog state not one-hot");
   chk_kick_wins: assert property (kick && dead_state_reg == BWD_DEAD_RUN |-> !dead_hit)
      else $error("expiry despite kick");

   // ---------------------------------------------------------------
   // checks: events and interrupts
   // ---------------------------------------------------------------
   // an event in the cycle of its own clear must survive
   chk_irq_follows: assert property (1'b1 |=> O_IRQ == $past(|(status_reg & nmi_en_reg)))
      else $error("irq does not follow enabled status");
   chk_status_set_wins: assert property (ev[1] && clr[1] |=> status_reg[1])
      else $error("event lost against clear");

   cov_nmi: cover property (O_NMI);
   cov_cpu_rst: cover property ($rose(O_CPU_RST));
   cov_kick: cover property (kick && dead_count_reg > 3);
   cov_stall_park: cover property (stall_ctrl_reg[0] && frame_s2_reg && stall_count_reg == stall_limit_reg);
   cov_status_clear: cover property (status_reg[0] ##1 !status_reg[0]);
endmodule
`default_nettype wire

/* hw/bwd_pkg.sv */
// package: register map, field positions, reset values and bus-facing types
// assumes a 32-bit classic wishbone slave with word-aligned registers
package bwd_pkg;
   localparam int BWD_AW = 5;
   localparam logic [BWD_AW-1:0] BWD_OFF_STALL_CTRL = 5'h00;
   localparam logic [BWD_AW-1:0] BWD_OFF_STALL_LIMIT = 5'h04;
   localparam logic [BWD_AW-1:0] BWD_OFF_DEAD_CTRL = 5'h08;
   localparam logic [BWD_AW-1:0] BWD_OFF_DEAD_PERIOD = 5'h0C;
   localparam logic [BWD_AW-1:0] BWD_OFF_DEAD_CLEAR = 5'h10;
   localparam logic [BWD_AW-1:0] BWD_OFF_DEAD_ELAPSED = 5'h14;
   localparam logic [BWD_AW-1:0] BWD_OFF_NMI_ENABLE = 5'h18;
   localparam logic [BWD_AW-1:0] BWD_OFF_IRQ_STATUS = 5'h1C;
   localparam int BWD_EN_BIT = 0;
   localparam int BWD_KICK_BIT = 0;
   localparam int BWD_EV_STALL = 0;
   localparam int BWD_EV_DEAD = 1;
   localparam int BWD_NEV = 2;
   localparam logic [31:0] BWD_RST_LIMIT = 32'h8000_0000;
   localparam logic [31:0] BWD_RST_PERIOD = 32'h8000_0000;
   localparam logic [31:0] BWD_RST_ZERO = 32'h0000_0000;
   localparam logic [31:0] BWD_ONE = 32'h0000_0001;
   localparam logic [31:0] BWD_UNMAPPED = 32'h0000_0000;
   // reset pulse to the cpu lasts this long
   localparam int BWD_CPU_RST_NS = 100;
   localparam int BWD_CLK_NS = 10;
   localparam logic [3:0] BWD_CPU_RST_CYC = 4'((BWD_CPU_RST_NS + BWD_CLK_NS - 1) / BWD_CLK_NS);

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [BWD_AW-1:0] adr;
      logic [31:0] dat;
   } bwd_wb_req_s;

   typedef enum logic [1:0] {
      BWD_DEAD_IDLE = 2'b01,
      BWD_DEAD_RUN = 2'b10
   } bwd_dead_e;
endpackage

/* sim/bwd_tb_top.sv */
// self-checking bench for the stall timer and deadman watchdog
// assumes bwd_pkg and bwd_top compiled first; one 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module bwd_tb_top;
   import bwd_pkg::*;
   logic clk, rstn, frame;
   bwd_wb_req_s req;
   logic [31:0] rdat, rd, lim, per, e1, e2;
   logic ack, nmi, cpu_rst, irq;
   int num_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   int nmi_cnt = 0;
   int rst_cnt = 0;

   bwd_top bwd_top_i (.I_CLK(clk), .I_RSTN(rstn), .I_WB_CYC(req.cyc), .I_WB_STB(req.stb), .I_WB_WE(req.we),
      .I_WB_SEL(req.sel), .I_WB_ADR(req.adr), .I_WB_DAT(req.dat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
      .I_BUS_FRAME(frame), .O_NMI(nmi), .O_CPU_RST(cpu_rst), .O_IRQ(irq));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ---------------------------------------------
   // watch outputs and cut a hang short
   // ---------------------------------------------
   always @(posedge clk) begin
      cycles <= cycles + 1;
      nmi_cnt <= nmi_cnt + int'(nmi === 1'b1);
      rst_cnt <= rst_cnt + int'(cpu_rst === 1'b1);
      if (cycles == 20000) begin
         num_errors++;
         summarize();
      end
   end

   task automatic summarize();
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one classic cycle; waits for ack under a bound
   task automatic wb(input logic w, input logic [BWD_AW-1:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk);
      req <= '{1'b1, 1'b1, w, s, a, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rd = rdat;
      check("ack", {31'h0, ack}, BWD_ONE);
      req <= '0;
   endtask

   task automatic wr(input logic [BWD_AW-1:0] a, input logic [31:0] d);
      wb(1'b1, a, d, 4'hF);
   endtask

   task automatic rd_chk(input string name, input logic [BWD_AW-1:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0000_0000, 4'hF);
      check(name, rd, exp);
   endtask

   task automatic stall_run(input int n);
      frame <= 1'b1;
      repeat (n) @(posedge clk);
      frame <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      req = '0;
      frame = 1'b0;
      rstn = 1'b0;
      void'($urandom(32'h3C69));
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rd_chk("stall_ctrl", BWD_OFF_STALL_CTRL, BWD_RST_ZERO);
      rd_chk("stall_limit", BWD_OFF_STALL_LIMIT, BWD_RST_LIMIT);
      rd_chk("dead_ctrl", BWD_OFF_DEAD_CTRL, BWD_RST_ZERO);
      rd_chk("dead_period", BWD_OFF_DEAD_PERIOD, BWD_RST_PERIOD);
      rd_chk("elapsed", BWD_OFF_DEAD_ELAPSED, BWD_RST_ZERO);
      wb(1'b1, BWD_OFF_STALL_LIMIT, 32'hFFFF_FFFF, 4'h1);
      rd_chk("limit_lane", BWD_OFF_STALL_LIMIT, 32'h8000_00FF);
      wr(BWD_OFF_DEAD_CLEAR, BWD_ONE);
      rd_chk("clear_rd", BWD_OFF_DEAD_CLEAR, BWD_RST_ZERO);
      // stall timer: short frames never reach the limit
      lim = 32'($urandom_range(12, 6));
      wr(BWD_OFF_STALL_LIMIT, lim);
      wr(BWD_OFF_NMI_ENABLE, 32'h0000_0003);
      wr(BWD_OFF_STALL_CTRL, 32'hFFFF_FFFF);
      rd_chk("ctrl_rsvd", BWD_OFF_STALL_CTRL, BWD_ONE);
      stall_run(lim - 2);
      stall_run(lim - 2);
      check("nmi_short", 32'(nmi_cnt), BWD_RST_ZERO);
      stall_run(lim + 8);
      check("nmi_long", {31'h0, nmi}, BWD_ONE);
      check("irq_stall", {31'h0, irq}, BWD_ONE);
      rd_chk("status_stall", BWD_OFF_IRQ_STATUS, BWD_ONE);
      wr(BWD_OFF_IRQ_STATUS, BWD_ONE);
      repeat (3) @(posedge clk);
      check("nmi_clr", {31'h0, nmi}, BWD_RST_ZERO);
      wr(BWD_OFF_STALL_CTRL, BWD_RST_ZERO);
      stall_run(lim + 8);
      rd_chk("status_off", BWD_OFF_IRQ_STATUS, BWD_RST_ZERO);
      wr(BWD_OFF_NMI_ENABLE, BWD_RST_ZERO);
      wr(BWD_OFF_STALL_CTRL, BWD_ONE);
      stall_run(lim + 8);
      check("nmi_masked", {31'h0, nmi}, BWD_RST_ZERO);
      rd_chk("status_masked", BWD_OFF_IRQ_STATUS, BWD_ONE);
      wr(BWD_OFF_IRQ_STATUS, BWD_ONE);
      wr(BWD_OFF_NMI_ENABLE, 32'h0000_0003);
      // deadman: program, enable, kick at random spacing
      per = 32'($urandom_range(40, 28));
      wr(BWD_OFF_DEAD_PERIOD, per);
      wr(BWD_OFF_DEAD_CTRL, BWD_ONE);
      repeat (6) begin
         repeat ($urandom_range(per / 3, 1)) @(posedge clk);
         wr(BWD_OFF_DEAD_CLEAR, BWD_ONE);
      end
      check("no_expiry", 32'(rst_cnt), BWD_RST_ZERO);
      repeat (5) @(posedge clk);
      wb(1'b0, BWD_OFF_DEAD_ELAPSED, 32'h0000_0000, 4'hF);
      e1 = rd;
      check("elapsed_lt", {31'h0, e1 < per && e1 > 0}, BWD_ONE);
      wr(BWD_OFF_DEAD_CLEAR, BWD_RST_ZERO);
      wb(1'b0, BWD_OFF_DEAD_ELAPSED, 32'h0000_0000, 4'hF);
      e2 = rd;
      check("kick_zero", {31'h0, e2 > e1}, BWD_ONE);
      repeat (per + 4) @(posedge clk);
      check("rst_width", 32'(rst_cnt), 32'(BWD_CPU_RST_CYC));
      rd_chk("status_dead", BWD_OFF_IRQ_STATUS, 32'h0000_0002);
      check("irq_dead", {31'h0, irq}, BWD_ONE);
      wr(BWD_OFF_DEAD_CTRL, BWD_RST_ZERO);
      repeat (2 * per) @(posedge clk);
      rd_chk("elapsed_off", BWD_OFF_DEAD_ELAPSED, BWD_RST_ZERO);
      check("rst_off", 32'(rst_cnt), 32'(BWD_CPU_RST_CYC));
      wr(BWD_OFF_IRQ_STATUS, 32'h0000_0002);
      repeat (3) @(posedge clk);
      check("irq_clr", {31'h0, irq}, BWD_RST_ZERO);
      summarize();
   end
endmodule
`default_nettype wire
